// [design/sshpr_pkg.sv]
// Constants shared by the strap sampling and host pin role logic
package sshpr_pkg;
    // Strap capture layout: {test, config select[2:0], host mode[1:0]}
    localparam int STRAP_W = 6;
    localparam int STRAP_TEST_BIT = 5;
    localparam int STRAP_CFG_LSB = 2;
    localparam int STRAP_MODE_LSB = 0;
    localparam logic [5:0] STRAP_RST = 6'h00;
    // Host interface mode codes
    localparam logic [1:0] MODE_I2C_SLAVE = 2'h0;
    localparam logic [1:0] MODE_SPI_SLAVE = 2'h1;
    localparam logic [1:0] MODE_SPI_MASTER = 2'h2;
    localparam logic [1:0] MODE_SPI_SLAVE_ROM = 2'h3;
    // Test with this config number starts normally but skips auto-configuration
    localparam logic [2:0] CFG_NO_AUTOCFG = 3'h3;
    // Auto-configuration EEPROM read
    localparam logic [7:0] EE_READ_CMD = 8'h03;
    localparam int EE_ADDR_SHIFT = 6;
    localparam logic [7:0] EE_CFG_BYTES = 8'h40;
    localparam logic [4:0] EE_HDR_LAST = 5'h17;
    localparam logic [4:0] EE_BYTE_LAST = 5'h07;
    // Serial clock half period in system clocks
    localparam logic [2:0] SCK_HALF = 3'h4;
    localparam int GPIO_N = 4;
endpackage

// [design/sshpr_sync.sv]
// Two flip-flop synchroniser for signals from outside the clock domain
`timescale 1ns/1ps
module sshpr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta_r <= INIT;
            q <= INIT;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// [design/sshpr_top.sv]
// Strap sampling at reset release and role switching of shared host pins
// Notes on behaviour
// - Reset pin low returns auto-configuration, GPIO and pin role state to defaults while it stays low; the strap capture register keeps its value.
// - Reset release samples three config select straps to pick stored configuration.
// - After reset config select pins are GPIO with real-time and latched status.
// - Reset release samples test strap; high enters test mode; then GPIO 3.
// - Reset release samples both host mode straps; they set the host mode.
// - As SPI master, drive chip select to read EEPROM, then make it input.
// - As SPI slave, drive read data on MISO during reads.
// - As SPI master, receive EEPROM data on MISO during auto-configuration.
// - As SPI master, drive the serial clock to access the EEPROM.
// - All strap values are captured into the capture register at reset release.
// - Config select straps read as a configuration number zero to seven.
`timescale 1ns/1ps
module sshpr_top
    import sshpr_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reset_n,
    input wire logic [3:0] gpio_i,
    output logic [3:0] gpio_o,
    output logic [3:0] gpio_oe,
    input wire logic [3:0] gpio_dir,
    input wire logic [3:0] gpio_out,
    input wire logic [3:0] gpio_latch_clr,
    output logic [3:0] gpio_rt,
    output logic [3:0] gpio_latched,
    input wire logic csn_i,
    output logic csn_o,
    output logic csn_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic slave_miso_bit,
    output logic host_csn_s,
    output logic host_sclk_s,
    output logic host_mosi_s,
    output logic [5:0] strap_capture_reg,
    output logic [2:0] config_number,
    output logic test_mode,
    output logic [1:0] host_mode,
    output logic autocfg_active,
    output logic autocfg_done,
    output logic [7:0] cfg_byte,
    output logic cfg_valid
);
    typedef enum logic [1:0] {AC_IDLE, AC_HDR, AC_DATA, AC_DONE} sshpr_ac_t;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic reset_n_s;
    logic reset_n_d_r;
    logic [3:0] gpio_s;
    logic miso_s;

    sshpr_sync #(.W(1), .INIT(1'b0)) u_rst_sync (
        .clk(clk), .sys_rst(sys_rst), .d(reset_n), .q(reset_n_s)
    );
    sshpr_sync #(.W(4), .INIT(4'h0)) u_gpio_sync (
        .clk(clk), .sys_rst(sys_rst), .d(gpio_i), .q(gpio_s)
    );
    sshpr_sync #(.W(4), .INIT(4'hf)) u_host_sync (
        .clk(clk), .sys_rst(sys_rst),
        .d({csn_i, sclk_i, mosi_i, miso_i}),
        .q({host_csn_s, host_sclk_s, host_mosi_s, miso_s})
    );

    // Internal reset covers both the system reset and the reset pin
    logic rst_int;
    logic rst_rise;
    assign rst_int = sys_rst | ~reset_n_s;
    assign rst_rise = reset_n_s & ~reset_n_d_r;

    // ----------------------------------------
    // Strap capture
    // ----------------------------------------
    logic [5:0] strap_nxt;
    logic [5:0] strap_now;
    logic [5:0] strap_r;
    logic [2:0] cfg_strap;
    logic test_strap;
    logic [1:0] mode_strap;

    // Pins are not driven during reset, so their levels are the straps
    assign strap_now = {gpio_s[3], gpio_s[2:0], miso_s, host_csn_s};
    assign cfg_strap = strap_r[STRAP_CFG_LSB +: 3];
    assign test_strap = strap_r[STRAP_TEST_BIT];
    assign mode_strap = strap_r[STRAP_MODE_LSB +: 2];

    always_comb
    begin
        strap_nxt = strap_r;
        if (sys_rst)
            strap_nxt = STRAP_RST;
        else if (rst_rise)
            strap_nxt = strap_now;
    end

    always_ff @(posedge clk)
    begin
        strap_r <= strap_nxt;
        reset_n_d_r <= sys_rst ? 1'b0 : reset_n_s;
    end

    assign strap_capture_reg = strap_r;
    assign config_number = cfg_strap;
    assign test_mode = test_strap;
    assign host_mode = mode_strap;

    // ----------------------------------------
    // EEPROM auto-configuration master
    // ----------------------------------------
    sshpr_ac_t st_r, st_nxt;
    logic [2:0] div_r, div_nxt;
    logic sck_r, sck_nxt;
    logic [23:0] sh_r, sh_nxt;
    logic [4:0] bit_r, bit_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic [7:0] rx_r, rx_nxt;
    logic [7:0] byte_r, byte_nxt;
    logic valid_r, valid_nxt;
    logic go_master;
    logic tick;
    logic sck_fall;
    logic ac_busy;

    // Test with config three skips the load but otherwise starts normally
    assign go_master = (mode_strap == MODE_SPI_MASTER) &&
                       !(test_strap && cfg_strap == CFG_NO_AUTOCFG);
    assign tick = (div_r == SCK_HALF - 3'h1);
    assign sck_fall = tick & sck_r;
    assign ac_busy = (st_r == AC_HDR) || (st_r == AC_DATA);

    always_comb
    begin
        st_nxt = st_r;
        div_nxt = ac_busy ? (tick ? 3'h0 : div_r + 3'h1) : 3'h0;
        sck_nxt = ac_busy ? (sck_r ^ tick) : 1'b0;
        sh_nxt = sh_r;
        bit_nxt = bit_r;
        cnt_nxt = cnt_r;
        rx_nxt = rx_r;
        byte_nxt = byte_r;
        valid_nxt = 1'b0;
        case (st_r)
            AC_IDLE:
            begin
                if (reset_n_d_r && go_master)
                begin
                    st_nxt = AC_HDR;
                    sh_nxt = {EE_READ_CMD, 16'(16'(cfg_strap) << EE_ADDR_SHIFT)};
                    bit_nxt = 5'h0;
                    cnt_nxt = 8'h00;
                end
                else if (reset_n_d_r)
                    st_nxt = AC_DONE;
            end
            AC_HDR:
            begin
                if (sck_fall)
                begin
                    sh_nxt = {sh_r[22:0], 1'b0};
                    bit_nxt = (bit_r == EE_HDR_LAST) ? 5'h0 : bit_r + 5'h1;
                    if (bit_r == EE_HDR_LAST)
                        st_nxt = AC_DATA;
                end
            end
            AC_DATA:
            begin
                // Sample at the end of the high phase: the pin trails sck_r by one
                // flop and miso_s trails the pin by two, so this sees the bit after
                // the pin's rising edge and leaves the EEPROM its output delay
                if (sck_fall)
                begin
                    rx_nxt = {rx_r[6:0], miso_s};
                    bit_nxt = (bit_r == EE_BYTE_LAST) ? 5'h0 : bit_r + 5'h1;
                    if (bit_r == EE_BYTE_LAST)
                    begin
                        byte_nxt = {rx_r[6:0], miso_s};
                        valid_nxt = 1'b1;
                        cnt_nxt = cnt_r + 8'h01;
                        if (cnt_r == EE_CFG_BYTES - 8'h01)
                            st_nxt = AC_DONE;
                    end
                end
            end
            AC_DONE:
                st_nxt = AC_DONE;
            default:
                st_nxt = AC_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst_int)
        begin
            st_r <= AC_IDLE;
            div_r <= 3'h0;
            sck_r <= 1'b0;
            sh_r <= 24'h000000;
            bit_r <= 5'h0;
            cnt_r <= 8'h00;
            rx_r <= 8'h00;
            byte_r <= 8'h00;
            valid_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            div_r <= div_nxt;
            sck_r <= sck_nxt;
            sh_r <= sh_nxt;
            bit_r <= bit_nxt;
            cnt_r <= cnt_nxt;
            rx_r <= rx_nxt;
            byte_r <= byte_nxt;
            valid_r <= valid_nxt;
        end
    end

    assign cfg_byte = byte_r;
    assign cfg_valid = valid_r;

    // ----------------------------------------
    // Pin roles and GPIO status
    // ----------------------------------------
    logic [3:0] gpo_nxt, gpoe_nxt, lat_nxt, rt_nxt;
    logic [3:0] gpo_r, gpoe_r, lat_r, rt_r;
    logic [7:0] pin_nxt, pin_r;
    logic act_nxt, act_r, done_nxt, done_r;
    logic slave_mode;

    assign slave_mode = (mode_strap == MODE_SPI_SLAVE) || (mode_strap == MODE_SPI_SLAVE_ROM);

    always_comb
    begin
        gpo_nxt = 4'h0;
        gpoe_nxt = 4'h0;
        rt_nxt = 4'h0;
        lat_nxt = 4'h0;
        pin_nxt = 8'h00;
        act_nxt = 1'b0;
        done_nxt = 1'b0;
        // Everything stays off the pins in reset so straps read cleanly
        if (!rst_int)
        begin
            gpo_nxt = gpio_out;
            gpoe_nxt = gpio_dir;
            rt_nxt = gpio_s;
            // Set wins over a clear in the same cycle
            lat_nxt = (lat_r & ~gpio_latch_clr) | gpio_s;
            act_nxt = ac_busy;
            done_nxt = (st_r == AC_DONE);
            // Order: csn o/oe, sclk o/oe, mosi o/oe, miso o/oe
            if (ac_busy)
                pin_nxt = {1'b0, 1'b1, sck_r, 1'b1, sh_r[23], 1'b1, 2'b00};
            else if (slave_mode && !host_csn_s)
                pin_nxt = {6'h00, slave_miso_bit, 1'b1};
        end
    end

    always_ff @(posedge clk)
    begin
        gpo_r <= gpo_nxt;
        gpoe_r <= gpoe_nxt;
        rt_r <= rt_nxt;
        lat_r <= lat_nxt;
        pin_r <= pin_nxt;
        act_r <= act_nxt;
        done_r <= done_nxt;
    end

    assign gpio_o = gpo_r;
    assign gpio_oe = gpoe_r;
    assign gpio_rt = rt_r;
    assign gpio_latched = lat_r;
    assign {csn_o, csn_oe, sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe} = pin_r;
    assign autocfg_active = act_r;
    assign autocfg_done = done_r;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_reset_pins_off: assert property (@(posedge clk) disable iff (sys_rst)
        rst_int |=> (gpio_oe == 4'h0) && !csn_oe && !sclk_oe && !mosi_oe && !miso_oe)
        else $error("pins driven during reset");
    a_strap_capture: assert property (@(posedge clk) disable iff (sys_rst)
        rst_rise |=> strap_capture_reg == $past(strap_now))
        else $error("straps not captured at release");
    a_strap_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !rst_rise |=> $stable(strap_capture_reg))
        else $error("strap settings changed");
    a_config_fields: assert property (@(posedge clk) disable iff (sys_rst)
        rst_rise |=> config_number == $past(gpio_s[2:0]) && test_mode == $past(gpio_s[3]))
        else $error("config number or test mode wrong");
    a_cs_master_low: assert property (@(posedge clk) disable iff (rst_int)
        ac_busy |=> csn_oe && !csn_o && sclk_oe && mosi_oe)
        else $error("chip select not driven in auto-config");
    a_cs_released: assert property (@(posedge clk) disable iff (rst_int)
        (st_r == AC_DONE) |=> !csn_oe && !sclk_oe)
        else $error("chip select still driven after auto-config");
    a_miso_slave_drive: assert property (@(posedge clk) disable iff (rst_int)
        (slave_mode && !host_csn_s && !ac_busy) |=> miso_oe && (miso_o == $past(slave_miso_bit)))
        else $error("read data not on MISO");
    a_sck_half_period: assert property (@(posedge clk) disable iff (rst_int)
        $rose(sck_r) && ac_busy |=> sck_r [*3] ##1 !sck_r)
        else $error("serial clock high time wrong");
    a_gpio_latch_set: assert property (@(posedge clk) disable iff (rst_int)
        gpio_s[0] |=> gpio_latched[0] && gpio_rt[0])
        else $error("GPIO latched status missed");
    a_rx_byte: assert property (@(posedge clk) disable iff (rst_int)
        (st_r == AC_DATA) && sck_fall && (bit_r == EE_BYTE_LAST) |=>
            cfg_valid && cfg_byte == $past({rx_r[6:0], miso_s}))
        else $error("EEPROM byte not delivered");

    c_autocfg_done: cover property (@(posedge clk) disable iff (sys_rst)
        $rose(autocfg_done) && host_mode == MODE_SPI_MASTER);
    c_slave_read: cover property (@(posedge clk) disable iff (sys_rst) $rose(miso_oe));
    c_test_skip: cover property (@(posedge clk) disable iff (sys_rst)
        rst_rise ##1 (test_mode && config_number == CFG_NO_AUTOCFG));
endmodule

// [tb/sshpr_ee_model.sv]
// Behavioural serial EEPROM on the far side of the auto-configuration port
`timescale 1ns/1ps
module sshpr_ee_model
(
    input wire logic clk,
    input wire logic sel,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic [7:0] dly,
    output logic miso,
    output logic miso_en,
    output logic [23:0] hdr
);
    int cnt = 0;
    int idx;
    logic [15:0] addr;
    logic [7:0] data;

    function automatic logic [7:0] ee_byte(input logic [15:0] a);
        return a[7:0] ^ 8'h5a;
    endfunction

    initial
    begin
        miso = 1'b0;
        miso_en = 1'b0;
        hdr = 24'h000000;
    end

    // Deselected line shows a changing pattern, never the last bit
    always @(posedge clk)
    begin
        miso_en <= sel;
        if (!sel)
        begin
            cnt <= 0;
            miso <= ~miso;
        end
    end

    // Command and address shift in on the rising serial edge
    always @(posedge sclk)
    begin
        if (sel)
        begin
            if (cnt < 24)
                hdr <= {hdr[22:0], mosi};
            cnt <= cnt + 1;
        end
    end

    // Data leaves on the falling edge; dly models a slow part
    always @(negedge sclk)
    begin
        if (sel)
        begin
            idx = cnt - 24;
            addr = hdr[15:0] + 16'(idx / 8);
            data = ee_byte(addr);
            if (cnt >= 24)
                miso <= #(dly) data[3'(7 - idx % 8)];
            else
                miso <= ~miso;
        end
    end
endmodule

// [tb/sshpr_top_tb_top.sv]
// Self-checking bench for strap capture and shared host pin roles
`timescale 1ns/1ps
module sshpr_top_tb_top
    import sshpr_pkg::*;
;
    logic clk = 1'b0, sys_rst = 1'b1, reset_n = 1'b0, slave_miso_bit = 1'b0;
    logic tb_csn = 1'b1, tb_miso = 1'b0, tb_sclk = 1'b0, tb_mosi = 1'b1;
    logic [3:0] tb_gpio = 4'h0, gpio_dir = 4'h0, gpio_out = 4'h0, gpio_latch_clr = 4'h0;
    logic [3:0] gpio_o, gpio_oe, gpio_rt, gpio_latched;
    logic csn_o, csn_oe, miso_o, miso_oe, sclk_o, sclk_oe, mosi_o, mosi_oe;
    logic host_csn_s, host_sclk_s, host_mosi_s, test_mode, autocfg_active, autocfg_done;
    logic cfg_valid, ee_miso, ee_en;
    logic [5:0] strap_capture_reg;
    logic [2:0] config_number;
    logic [1:0] host_mode;
    logic [7:0] cfg_byte;
    logic [23:0] ee_hdr;
    logic [7:0] exp_q[$];
    int fails = 0, checks_done = 0, seed;
    logic [31:0] r;

    // Pin levels from every party's enable
    wire logic [3:0] gpio_pin = (gpio_oe & gpio_o) | (~gpio_oe & tb_gpio);
    wire logic csn_pin = csn_oe ? csn_o : tb_csn;
    wire logic sclk_pin = sclk_oe ? sclk_o : tb_sclk;
    wire logic mosi_pin = mosi_oe ? mosi_o : tb_mosi;
    wire logic miso_pin = miso_oe ? miso_o : (ee_en ? ee_miso : tb_miso);

    always #5 clk = ~clk;

    sshpr_top u_sshpr_top (.clk(clk), .sys_rst(sys_rst), .reset_n(reset_n),
        .gpio_i(gpio_pin), .gpio_o(gpio_o), .gpio_oe(gpio_oe), .gpio_dir(gpio_dir),
        .gpio_out(gpio_out), .gpio_latch_clr(gpio_latch_clr), .gpio_rt(gpio_rt),
        .gpio_latched(gpio_latched), .csn_i(csn_pin), .csn_o(csn_o), .csn_oe(csn_oe),
        .miso_i(miso_pin), .miso_o(miso_o), .miso_oe(miso_oe), .sclk_i(sclk_pin),
        .sclk_o(sclk_o), .sclk_oe(sclk_oe), .mosi_i(mosi_pin), .mosi_o(mosi_o),
        .mosi_oe(mosi_oe), .slave_miso_bit(slave_miso_bit), .host_csn_s(host_csn_s),
        .host_sclk_s(host_sclk_s), .host_mosi_s(host_mosi_s),
        .strap_capture_reg(strap_capture_reg), .config_number(config_number),
        .test_mode(test_mode), .host_mode(host_mode), .autocfg_active(autocfg_active),
        .autocfg_done(autocfg_done), .cfg_byte(cfg_byte), .cfg_valid(cfg_valid));

    sshpr_ee_model u_sshpr_ee_model (.clk(clk), .sel(csn_oe & ~csn_o), .sclk(sclk_pin),
        .mosi(mosi_pin), .dly(8'h0f), .miso(ee_miso), .miso_en(ee_en), .hdr(ee_hdr));

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Oldest expected byte against each byte the engine reports
    always @(posedge clk)
    begin
        if (cfg_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk(24'hffffff, 24'(cfg_byte));
            else
                chk(24'(cfg_byte), 24'(exp_q.pop_front()));
        end
    end

    // Strap order {test, cfg[2:0], if1, if0}
    task automatic strap_reset(input logic [5:0] s);
        @(posedge clk);
        reset_n <= 1'b0;
        tb_gpio <= s[5:2];
        tb_miso <= s[1];
        tb_csn <= s[0];
        repeat (110) @(posedge clk);
        chk(24'({gpio_oe, csn_oe, miso_oe, sclk_oe, mosi_oe, autocfg_active}), 24'h0);
        reset_n <= 1'b1;
        repeat (8) @(posedge clk);
        tb_csn <= 1'b1;
        tb_gpio <= 4'h0;
        @(negedge clk);
        chk(24'(strap_capture_reg), 24'(s));
        chk(24'({test_mode, config_number, host_mode}), 24'(s));
        @(posedge clk);
        r = $random(seed);
        tb_gpio <= r[3:0];
        tb_miso <= r[4];
        repeat (10) @(posedge clk);
        chk(24'(strap_capture_reg), 24'(s));
        tb_gpio <= 4'h0;
    endtask

    // Host frame with a link clock of 125 ns unrelated to clk
    task automatic link_frame(input logic [1:0] m);
        logic b;
        @(posedge clk);
        tb_sclk <= (m == MODE_I2C_SLAVE);
        tb_csn <= 1'b0;
        repeat (4) @(posedge clk);
        fork
            repeat (6) #62.5 tb_sclk <= ~tb_sclk;
            repeat (20)
            begin
                b = r[0];
                slave_miso_bit <= b;
                r = $random(seed);
                @(posedge clk);
                @(negedge clk);
                chk(24'(miso_oe), 24'(m != MODE_I2C_SLAVE));
                if (m != MODE_I2C_SLAVE)
                    chk(24'(miso_o), 24'(b));
                @(posedge clk);
            end
        join
        repeat (4) @(posedge clk);
        chk(24'(host_sclk_s), 24'(tb_sclk));
        tb_csn <= 1'b1;
        repeat (5) @(posedge clk);
        chk(24'({miso_oe, sclk_oe, mosi_oe}), 24'h0);
    endtask

    task automatic master_run(input logic [2:0] cfg, input logic abort);
        logic [15:0] a;
        for (int k = 0; k < 64; k++)
        begin
            a = 16'({cfg, 6'h00}) + 16'(k);
            exp_q.push_back(a[7:0] ^ 8'h5a);
        end
        strap_reset({1'b0, cfg, MODE_SPI_MASTER});
        if (abort)
        begin
            repeat (300) @(posedge clk);
            reset_n <= 1'b0;
            repeat (6) @(posedge clk);
            chk(24'({csn_oe, sclk_oe, mosi_oe, autocfg_active}), 24'h0);
            exp_q.delete();
        end
        else
        begin
            for (int i = 0; i < 6000 && autocfg_done !== 1'b1; i++) @(posedge clk);
            @(negedge clk);
            chk(ee_hdr, {EE_READ_CMD, 16'({cfg, 6'h00})});
            chk(24'(exp_q.size()), 24'h0);
            chk(24'({autocfg_done, autocfg_active, csn_oe, sclk_oe}), 24'h800000 >> 20);
        end
        $display("test master read cfg %0d abort %0d done", cfg, abort);
    endtask

    initial
    begin
        #200_000;
        fails++;
        results();
    end

    initial
    begin
        logic seen;
        logic [3:0] lvl;
        seed = 50735;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        for (int m = 0; m < 4; m++)
        begin
            if (m != 2)
            begin
                r = $random(seed);
                strap_reset({1'b0, r[2:0], 2'(m)});
                link_frame(2'(m));
                $display("test host mode %0d done", m);
            end
        end
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            gpio_dir <= 4'h0;
            gpio_latch_clr <= 4'hf;
            repeat (8) @(posedge clk);
            gpio_latch_clr <= 4'h0;
            r = $random(seed);
            lvl = (r[3:0] & r[7:4]) | (~r[3:0] & r[11:8]);
            gpio_dir <= r[3:0];
            gpio_out <= r[7:4];
            // Far side moves once the enables have, so no contention glitch gets latched
            @(posedge clk);
            tb_gpio <= r[11:8];
            repeat (6) @(negedge clk);
            chk(24'({gpio_oe, gpio_o}), 24'({r[3:0], r[7:4]}));
            chk(24'({gpio_rt, gpio_latched}), 24'({lvl, lvl}));
            @(posedge clk);
            gpio_dir <= 4'h0;
            tb_gpio <= 4'h0;
            repeat (6) @(negedge clk);
            chk(24'({gpio_rt, gpio_latched}), 24'(lvl));
        end
        $display("test gpio done");
        master_run(3'(r[14:12]), 1'b0);
        master_run(3'(r[18:16]), 1'b1);
        strap_reset({1'b1, CFG_NO_AUTOCFG, MODE_SPI_MASTER});
        seen = 1'b0;
        repeat (20)
        begin
            @(negedge clk);
            seen = seen | csn_oe | sclk_oe | mosi_oe;
        end
        chk(24'({seen, autocfg_done, autocfg_active}), 24'h2);
        $display("test skipped auto-configuration done");
        results();
    end
endmodule
